// File: logic/motor_status_defines.vh
// Summary of operation
// - Multi-byte variables read out low byte first.
// - Host selects variable by byte offset.
// - Serial mode: raw input equals target, max 4095.
// - Analog mode: raw input is converted input voltage.
// - Pulse mode: raw input counts two-thirds microsecond steps.
// - Non-serial modes: target is scaled raw input.
// - Open loop: drive target is target minus 2048.
// - Closed loop: drive target is negated PID sum.
// - Force target command replaces computed drive target.
// - Frequency feedback: 2048 offset by tachometer frequency.
// - No feedback mode: raw feedback reads zero.
// - Analog feedback: raw feedback is converted voltage.
// - Closed loop: each period integral adds error, clamped to limit.
// - Halting error: target kept, applied level ramps down.
// - Applied level is limited target, magnitude at most 600.
// - Plus or minus 600 means full speed.
// - Force duty command overrides applied level directly.
// - Coarse current is upper eight current bits.
// - Overrun flag set when last period overran.
// - Period counter increments per period, wraps after 65535.
`ifndef MOTOR_STATUS_DEFINES_VH
`define MOTOR_STATUS_DEFINES_VH

// Byte offsets of the variables within the variable area.
`define OFF_RAW_INPUT      8'h00
`define OFF_TARGET         8'h02
`define OFF_RAW_FEEDBACK   8'h04
`define OFF_SCALED_FB      8'h06
`define OFF_ERROR_SUM      8'h08
`define OFF_DRIVE_TARGET   8'h0A
`define OFF_APPLIED_DRIVE  8'h0C
`define OFF_COARSE_CURRENT 8'h0E
`define OFF_OVERRUN        8'h0F
`define OFF_PERIOD_COUNT   8'h10
`define VAR_BYTES          8'h12

// Input and feedback mode encodings.
`define IN_SERIAL          2'h0
`define IN_ANALOG          2'h1
`define IN_PULSE           2'h2
`define FB_NONE            2'h0
`define FB_ANALOG          2'h1
`define FB_FREQ            2'h2

// Force mode encodings.
`define FORCE_NONE         2'h0
`define FORCE_TARGET       2'h1
`define FORCE_DUTY         2'h2

// Value limits.
`define TARGET_MAX         32'h0000_0FFF
`define FB_MIDPOINT        32'h0000_0800
`define DRIVE_FULL         32'h0000_0258
`define S16_MAX            32'h0000_7FFF
`define S16_MIN            32'hFFFF_8000
`define PULSE_STEP_SHIFT   3
`define SCALE_SHIFT        8
`define PID_SHIFT          4
`define CURRENT_HI_LSB     8

// Clock timing: 25 MHz clock, one millisecond in nanoseconds.
`define CLOCK_PERIOD_NS    40
`define MS_IN_NS           1000000
`define CYCLES_PER_MS      (`MS_IN_NS / `CLOCK_PERIOD_NS)

// One-hot states of the period sequencer.
`define ST_IDLE            5'h01
`define ST_SAMPLE          5'h02
`define ST_SCALE           5'h04
`define ST_PID             5'h08
`define ST_DRIVE           5'h10

`endif

// File: logic/loop_period_timer.v
`timescale 1ns/1ns
`default_nettype none
`include "motor_status_defines.vh"

// Produces a one-cycle tick at the start of every control period.
module loop_period_timer #(
    parameter CYCLES_PER_MS = `CYCLES_PER_MS
) (
    // Clock and reset
    input  wire        clock_i,
    input  wire        rst_i,
    // Configuration
    input  wire [15:0] period_ms_i,
    // Tick out
    output reg         tick_o
);

    reg [31:0] prescale_reg;   // Cycles within the current millisecond.
    reg [15:0] ms_reg;         // Milliseconds within the current period.
    wire       ms_done;        // Last cycle of a millisecond.
    wire [15:0] period_last;   // Final millisecond index of a period.

    assign ms_done = (prescale_reg == CYCLES_PER_MS - 1);
    // A zero period would never tick, so it is treated as one millisecond.
    assign period_last = (period_ms_i == 16'h0000) ? 16'h0000 : period_ms_i - 16'h0001;

    // Millisecond prescaler and period counter; the tick is a clean enable.
    always @(posedge clock_i) begin
        if (rst_i) begin
            prescale_reg <= 32'h0000_0000;
            ms_reg       <= 16'h0000;
            tick_o       <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (ms_done) begin
                prescale_reg <= 32'h0000_0000;
                if (ms_reg >= period_last) begin
                    // Compare with >= so a shortened period takes effect at once.
                    ms_reg <= 16'h0000;
                    tick_o <= 1'b1;
                end else begin
                    ms_reg <= ms_reg + 16'h0001;
                end
            end else begin
                prescale_reg <= prescale_reg + 32'h0000_0001;
            end
        end
    end

endmodule
`default_nettype wire

// File: logic/motor_status_bank.v
`timescale 1ns/1ns
`default_nettype none
`include "motor_status_defines.vh"

// Status variable bank of a closed-loop motor controller with byte read-out.
module motor_status_bank #(
    parameter CYCLES_PER_MS = `CYCLES_PER_MS
) (
    // Clock and reset
    input  wire        clock_i,
    input  wire        rst_i,
    // Mode configuration
    input  wire [1:0]  input_mode_i,
    input  wire [1:0]  feedback_mode_i,
    input  wire [15:0] pid_period_ms_i,
    // Measurements
    input  wire        sample_valid_i,
    input  wire [11:0] analog_input_i,
    input  wire [11:0] analog_feedback_i,
    input  wire [15:0] pulse_width_i,
    input  wire [12:0] tach_freq_i,
    input  wire [15:0] current_ma_i,
    // Scaling and loop settings
    input  wire [11:0] in_offset_i,
    input  wire [11:0] in_gain_i,
    input  wire [11:0] fb_offset_i,
    input  wire [11:0] fb_gain_i,
    input  wire [7:0]  kp_i,
    input  wire [7:0]  ki_i,
    input  wire [7:0]  kd_i,
    input  wire [14:0] integral_limit_i,
    input  wire [9:0]  max_duty_i,
    input  wire [9:0]  decel_step_i,
    input  wire        error_halt_i,
    // Commands
    input  wire        set_target_i,
    input  wire [15:0] target_value_i,
    input  wire        force_target_i,
    input  wire        force_duty_i,
    input  wire [15:0] force_value_i,
    input  wire        force_release_i,
    // Variable read port
    input  wire        rd_start_i,
    input  wire [7:0]  rd_offset_i,
    input  wire [5:0]  rd_count_i,
    input  wire        rd_ready_i,
    output wire        rd_busy_o,
    output reg         rd_valid_o,
    output reg  [7:0]  rd_data_o,
    // Motor drive and status
    output reg  [15:0] applied_drive_o,
    output reg  [1:0]  force_mode_o,
    output wire        period_tick_o
);

    // Variable storage, updated stage by stage through the period sequence; the period counter on each tick.
    reg [15:0] raw_input_reg;
    reg [15:0] commanded_target_reg;
    reg [15:0] raw_feedback_reg;
    reg [15:0] scaled_feedback_reg;
    reg [15:0] error_sum_reg;
    reg [15:0] drive_level_target_reg;
    reg [7:0]  coarse_motor_current_reg;
    reg        loop_overrun_flag_reg;
    reg [15:0] loop_period_counter_reg;

    // Sequencer and command state.
    reg [4:0]  state_reg;
    reg [15:0] cmd_target_reg;       // Last serial target command.
    reg [15:0] prev_error_reg;       // Error of the previous period.
    reg        late_reg;             // A tick came while still busy.
    reg [15:0] force_reg;            // Value of the active force command.

    // Read engine state and snapshot.
    reg [7:0]  snap_mem [0:17];
    reg [7:0]  rd_ptr_reg;
    reg [5:0]  rd_left_reg;
    reg        rd_load_reg;
    wire       rd_take;
    wire [143:0] live_bytes;
    integer    k;

    // Combinational loop arithmetic.
    integer    err_w;
    integer    int_w;
    integer    lim_w;
    integer    pid_w;
    integer    dt_w;
    integer    cap_w;
    integer    drv_w;
    integer    step_w;
    reg [15:0] in_raw_w;
    reg [15:0] fb_raw_w;

    // Clamps a signed value into a range and returns its low sixteen bits.
    function [15:0] clamp16;
        input integer v;
        input integer lo;
        input integer hi;
        integer r;
        begin
            r = v;
            if (r < lo) begin
                r = lo;
            end
            if (r > hi) begin
                r = hi;
            end
            clamp16 = r[15:0];
        end
    endfunction

    // Linear scaling: subtract offset, multiply by gain in 1/256 units, cap.
    function [15:0] scale12;
        input [15:0] raw;
        input [11:0] off;
        input [11:0] gain;
        integer d;
        begin
            d = raw - off;
            if (d < 0) begin
                d = 0;
            end
            d = (d * gain) >>> `SCALE_SHIFT;
            scale12 = clamp16(d, 0, `TARGET_MAX);
        end
    endfunction

    // Period tick source.
    loop_period_timer #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) period_timer (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .period_ms_i (pid_period_ms_i),
        .tick_o      (period_tick_o)
    );

    // Raw input and feedback selection by mode.
    always @* begin
        case (input_mode_i)
            `IN_ANALOG: begin
                in_raw_w = {4'h0, analog_input_i};
            end
            `IN_PULSE: begin
                in_raw_w = pulse_width_i >> `PULSE_STEP_SHIFT;
            end
            default: begin
                in_raw_w = cmd_target_reg;
            end
        endcase
        case (feedback_mode_i)
            `FB_ANALOG: begin
                fb_raw_w = {4'h0, analog_feedback_i};
            end
            `FB_FREQ: begin
                // Signed tachometer reading moves the midpoint either way.
                fb_raw_w = clamp16($signed(`FB_MIDPOINT) + $signed(tach_freq_i),
                                   0, `TARGET_MAX);
            end
            default: begin
                fb_raw_w = 16'h0000;
            end
        endcase
    end

    // Loop arithmetic on the latched variables.
    always @* begin
        err_w = scaled_feedback_reg - commanded_target_reg;
        lim_w = integral_limit_i;
        int_w = $signed(error_sum_reg) + err_w;
        int_w = $signed(clamp16(int_w, -lim_w, lim_w));
        // Gains are widened as signed so negative errors shift arithmetically.
        pid_w = (($signed({1'b0, kp_i}) * err_w) >>> `PID_SHIFT)
              + (($signed({1'b0, ki_i}) * int_w) >>> `PID_SHIFT)
              + (($signed({1'b0, kd_i}) * (err_w - $signed(prev_error_reg))) >>> `PID_SHIFT);
        if (force_mode_o == `FORCE_TARGET) begin
            dt_w = $signed(force_reg);
        end else if (feedback_mode_i == `FB_NONE) begin
            dt_w = commanded_target_reg - `FB_MIDPOINT;
        end else begin
            dt_w = -pid_w;
        end
        dt_w = $signed(clamp16(dt_w, `S16_MIN, `S16_MAX));
        // The motor limit can only narrow the full-speed range.
        cap_w = (max_duty_i > `DRIVE_FULL) ? `DRIVE_FULL : max_duty_i;
        step_w = decel_step_i;
        drv_w = $signed(applied_drive_o);
        if (force_mode_o == `FORCE_DUTY) begin
            drv_w = $signed(force_reg);
        end else if (error_halt_i) begin
            // A zero step would never stop the motor, so it stops at once.
            if (step_w == 0 || (drv_w <= step_w && drv_w >= -step_w)) begin
                drv_w = 0;
            end else if (drv_w > 0) begin
                drv_w = drv_w - step_w;
            end else begin
                drv_w = drv_w + step_w;
            end
        end else begin
            drv_w = dt_w;
            if (drv_w > cap_w) begin
                drv_w = cap_w;
            end
            if (drv_w < -cap_w) begin
                drv_w = -cap_w;
            end
        end
        drv_w = $signed(clamp16(drv_w, -`DRIVE_FULL, `DRIVE_FULL));
    end

    // Command capture; force modes hold until released or replaced.
    always @(posedge clock_i) begin
        if (rst_i) begin
            cmd_target_reg <= 16'h0000;
            force_mode_o   <= `FORCE_NONE;
            force_reg      <= 16'h0000;
        end else begin
            if (set_target_i) begin
                cmd_target_reg <= clamp16(target_value_i, 0, `TARGET_MAX);
            end
            if (force_duty_i) begin
                force_mode_o <= `FORCE_DUTY;
                force_reg    <= force_value_i;
            end else if (force_target_i) begin
                force_mode_o <= `FORCE_TARGET;
                force_reg    <= force_value_i;
            end else if (force_release_i || set_target_i) begin
                // A new target hands control back to the loop.
                force_mode_o <= `FORCE_NONE;
            end
        end
    end

    // Period sequencer: sample, scale, run the loop, update the drive.
    always @(posedge clock_i) begin
        if (rst_i) begin
            state_reg                <= `ST_IDLE;
            raw_input_reg            <= 16'h0000;
            commanded_target_reg     <= 16'h0000;
            raw_feedback_reg         <= 16'h0000;
            scaled_feedback_reg      <= 16'h0000;
            error_sum_reg            <= 16'h0000;
            drive_level_target_reg   <= 16'h0000;
            applied_drive_o          <= 16'h0000;
            coarse_motor_current_reg <= 8'h00;
            loop_overrun_flag_reg    <= 1'b0;
            loop_period_counter_reg  <= 16'h0000;
            prev_error_reg           <= 16'h0000;
            late_reg                 <= 1'b0;
        end else begin
            if (period_tick_o) begin
                // Natural 16-bit wrap takes 65535 back to zero.
                loop_period_counter_reg <= loop_period_counter_reg + 16'h0001;
            end
            case (state_reg)
                `ST_IDLE: begin
                    if (period_tick_o) begin
                        state_reg <= `ST_SAMPLE;
                    end
                end
                `ST_SAMPLE: begin
                    // Waiting for conversions is what can stretch a period.
                    if (period_tick_o) begin
                        late_reg <= 1'b1;
                    end
                    if (sample_valid_i) begin
                        raw_input_reg    <= in_raw_w;
                        raw_feedback_reg <= fb_raw_w;
                        coarse_motor_current_reg <=
                            current_ma_i[15:`CURRENT_HI_LSB];
                        state_reg <= `ST_SCALE;
                    end
                end
                `ST_SCALE: begin
                    if (period_tick_o) begin
                        late_reg <= 1'b1;
                    end
                    if (input_mode_i == `IN_SERIAL) begin
                        commanded_target_reg <= cmd_target_reg;
                    end else begin
                        commanded_target_reg <= scale12(raw_input_reg,
                                                in_offset_i, in_gain_i);
                    end
                    if (feedback_mode_i == `FB_NONE) begin
                        scaled_feedback_reg <= 16'h0000;
                    end else begin
                        scaled_feedback_reg <= scale12(raw_feedback_reg,
                                               fb_offset_i, fb_gain_i);
                    end
                    state_reg <= `ST_PID;
                end
                `ST_PID: begin
                    if (period_tick_o) begin
                        late_reg <= 1'b1;
                    end
                    if (feedback_mode_i != `FB_NONE) begin
                        error_sum_reg <= int_w[15:0];
                    end
                    prev_error_reg         <= err_w[15:0];
                    drive_level_target_reg <= dt_w[15:0];
                    state_reg <= `ST_DRIVE;
                end
                `ST_DRIVE: begin
                    applied_drive_o       <= drv_w[15:0];
                    loop_overrun_flag_reg <= late_reg | period_tick_o;
                    late_reg              <= 1'b0;
                    // A tick in this same cycle starts the next sequence right away; late ticks in earlier stages only set the flag.
                    state_reg <= period_tick_o ? `ST_SAMPLE : `ST_IDLE;
                end
                default: begin
                    state_reg <= `ST_IDLE;
                end
            endcase
        end
    end

    // Variable area image, little-endian within each variable.
    assign live_bytes = {loop_period_counter_reg,
                         7'h00, loop_overrun_flag_reg,
                         coarse_motor_current_reg,
                         applied_drive_o,
                         drive_level_target_reg,
                         error_sum_reg,
                         scaled_feedback_reg,
                         raw_feedback_reg,
                         commanded_target_reg,
                         raw_input_reg};

    // A read is taken only when idle and for a non-zero count.
    assign rd_take   = rd_start_i && !rd_busy_o && (rd_count_i != 6'h00);
    assign rd_busy_o = rd_load_reg | rd_valid_o;

    // Whole image copied at once, so no variable can tear mid-response.
    always @(posedge clock_i) begin
        if (rst_i) begin
            for (k = 0; k < `VAR_BYTES; k = k + 1) begin
                snap_mem[k] <= 8'h00;
            end
        end else if (rd_take) begin
            for (k = 0; k < `VAR_BYTES; k = k + 1) begin
                snap_mem[k] <= live_bytes[8*k +: 8];
            end
        end
    end

    // Byte streamer: one byte per accepted handshake, offsets past the area read 0.
    always @(posedge clock_i) begin
        if (rst_i) begin
            rd_ptr_reg  <= 8'h00;
            rd_left_reg <= 6'h00;
            rd_load_reg <= 1'b0;
            rd_valid_o  <= 1'b0;
            rd_data_o   <= 8'h00;
        end else if (rd_take) begin
            rd_ptr_reg  <= rd_offset_i;
            rd_left_reg <= rd_count_i;
            rd_load_reg <= 1'b1;
        end else if (rd_load_reg) begin
            rd_load_reg <= 1'b0;
            rd_valid_o  <= 1'b1;
            rd_data_o   <= (rd_ptr_reg < `VAR_BYTES) ? snap_mem[rd_ptr_reg[4:0]] : 8'h00;
        end else if (rd_valid_o && rd_ready_i) begin
            if (rd_left_reg == 6'h01) begin
                rd_valid_o  <= 1'b0;
                rd_left_reg <= 6'h00;
            end else begin
                rd_left_reg <= rd_left_reg - 6'h01;
                rd_ptr_reg  <= rd_ptr_reg + 8'h01;
                rd_data_o   <= (rd_ptr_reg + 8'h01 < `VAR_BYTES) ?
                               snap_mem[rd_ptr_reg[4:0] + 5'h01] : 8'h00;
            end
        end
    end

endmodule
`default_nettype wire

// File: testbench/motor_status_bank_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the bank.
module motor_status_checker #(
    parameter CYCLES_PER_MS = 4
) (
    input wire logic clock_i, rst_i, set_target_i, force_target_i, force_duty_i, force_release_i,
    input wire logic rd_start_i, rd_ready_i, rd_busy_o, rd_valid_o, period_tick_o,
    input wire logic [5:0] rd_count_i, input wire logic [7:0] rd_data_o,
    input wire logic [15:0] applied_drive_o, input wire logic [1:0] force_mode_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    chk_drive_mag: assert property ($signed(applied_drive_o) <= 600 && $signed(applied_drive_o) >= -600)
        else $error("applied level out of range");
    chk_read_answer: assert property (rd_start_i && !rd_busy_o && rd_count_i != 6'd0 |=> rd_busy_o && !rd_valid_o ##1 rd_valid_o)
        else $error("read answer not on time");
    chk_byte_hold: assert property (rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o))
        else $error("byte changed while stalled");
    chk_valid_end: assert property ($fell(rd_valid_o) |-> !rd_busy_o)
        else $error("busy after last byte");
    chk_tick_gap: assert property (period_tick_o |=> !period_tick_o [*3])
        else $error("period ticks too close");
    chk_force_duty: assert property (force_duty_i && !set_target_i && !force_release_i |=> force_mode_o == 2'h2)
        else $error("duty force not entered");
    chk_force_target: assert property (force_target_i && !force_duty_i && !set_target_i && !force_release_i |=> force_mode_o == 2'h1)
        else $error("target force not entered");
    chk_force_clear: assert property ((force_release_i || set_target_i) && !force_target_i && !force_duty_i |=> force_mode_o == 2'h0)
        else $error("force not released");
endmodule

bind motor_status_bank motor_status_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) motor_status_checker_inst (.*);
`default_nettype wire

// File: testbench/status_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host on the read port; a random ready pattern stalls some transfers.
module status_host_model (
    input  wire logic       clock_i,
    input  wire logic       busy_i,
    input  wire logic       valid_i,
    input  wire logic [7:0] data_i,
    output var  logic       start_o,
    output var  logic [7:0] offset_o,
    output var  logic [5:0] count_o,
    output var  logic       ready_o
);
    logic [7:0] got[$];        // Bytes of the last read.
    logic [7:0] pat = 8'h5a;   // Stall pattern.
    initial {start_o, offset_o, count_o, ready_o} = {1'b0, 8'hff, 6'h00, 1'b0};
    // The request is held one edge, taken there because the port is idle.
    task automatic read(input logic [7:0] off, input logic [5:0] cnt);
        int w;
        got.delete();
        w = 0;
        @(posedge clock_i);
        #1;
        start_o = 1'b1;
        offset_o = off;
        count_o = cnt;
        @(posedge clock_i);
        #1;
        start_o = 1'b0;
        offset_o = ~off;
        count_o = ~cnt;
        while (got.size() < cnt && w < 300) begin
            pat = {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
            ready_o = pat[0] | pat[1];
            @(negedge clock_i);
            if (valid_i === 1'b1 && ready_o) got.push_back(data_i);
            @(posedge clock_i);
            #1;
            w++;
        end
        ready_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// Bench: a reference model predicts the bytes the host reads back, skipping error sum and period count where marked.
module tb_top;
    logic        clock_i = 1'b0, rst_i = 1'b1, sample_valid_i = 1'b1, error_halt_i = 1'b0;
    logic        set_target_i = 1'b0, force_target_i = 1'b0, force_duty_i = 1'b0;
    logic        force_release_i = 1'b0;
    logic [1:0]  input_mode_i = 2'h0, feedback_mode_i = 2'h0;
    logic [15:0] pid_period_ms_i = 16'h0002, pulse_width_i = 16'h0000, current_ma_i = 16'h0000;
    logic [15:0] target_value_i = 16'h0000, force_value_i = 16'h0000;
    logic [11:0] analog_input_i = 12'h000, analog_feedback_i = 12'h000, in_gain_i = 12'h000;
    logic [11:0] in_offset_i = 12'h000, fb_offset_i = 12'h000, fb_gain_i = 12'h000;
    logic [12:0] tach_freq_i = 13'h0000;
    logic [7:0]  kp_i = 8'h00, ki_i = 8'h00, kd_i = 8'h00;  // Zero gains keep the PID sum at zero.
    logic [14:0] integral_limit_i = 15'h0005;
    logic [9:0]  max_duty_i = 10'h000, decel_step_i = 10'h000;  // Zero step stops at once.
    wire logic   rd_start_i, rd_ready_i, rd_busy_o, rd_valid_o, period_tick_o;
    wire logic [7:0]  rd_offset_i, rd_data_o;
    wire logic [5:0]  rd_count_i;
    wire logic [15:0] applied_drive_o;
    wire logic [1:0]  force_mode_o;
    integer err_total = 0, checks_done = 0, cycles = 0, ticks = 0;
    integer ev[0:9];  // Expected variables in map order.
    integer k, tv, fmode = 0, fval = 0, ib = 0, ov = 0;
    logic [15:0] rnd = 16'h0038;
    logic [63:0] w, x;
    logic [17:0] skip;
    motor_status_bank #(.CYCLES_PER_MS(4)) motor_status_bank_inst (.*);
    status_host_model status_host_model_inst (.clock_i, .busy_i(rd_busy_o), .valid_i(rd_valid_o),
        .data_i(rd_data_o), .start_o(rd_start_i), .offset_o(rd_offset_i), .count_o(rd_count_i),
        .ready_o(rd_ready_i));
    initial forever #20 clock_i = ~clock_i;
    // Ticks are counted mid-cycle, away from the edge that moves them.
    always @(negedge clock_i) if (period_tick_o === 1'b1) ticks = ticks + 1;
    always @(posedge clock_i) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            err_total = err_total + 1;
            test_done;
        end
    end
    function logic [15:0] r();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        return rnd;
    endfunction
    function integer clampi(input integer v, lo, hi);
        return v < lo ? lo : (v > hi ? hi : v);
    endfunction
    function integer scl(input integer raw, off, gain);
        return clampi(((raw > off ? raw - off : 0) * gain) / 256, 0, 4095);
    endfunction
    // Byte at an offset; the low byte of a word sits at the lower offset.
    function logic [7:0] eb(input integer j);
        integer v;
        v = j < 14 ? ev[j / 2] >> (8 * (j % 2)) : (j < 16 ? ev[j - 7] : (j < 18 ? ev[9] >> (8 * (j - 16)) : 0));
        return v[7:0];
    endfunction
    task cmp(input logic [7:0] g, input logic [7:0] e);
        checks_done = checks_done + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task test_done;
        $display("mismatches %0d of %0d checks", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Command pulse of one cycle: 0 set target, 1 force target, 2 force duty, 3 release.
    task cmd(input integer c, input integer v);
        @(posedge clock_i);
        #1;
        target_value_i = v[15:0];
        force_value_i = v[15:0];
        {set_target_i, force_target_i, force_duty_i, force_release_i} = 4'h8 >> c;
        @(posedge clock_i);
        #1;
        {set_target_i, force_target_i, force_duty_i, force_release_i} = 4'h0;
    endtask
    task periods(input integer n);
        repeat (n) begin
            @(negedge clock_i);
            while (period_tick_o !== 1'b1) @(negedge clock_i);
        end
    endtask
    task calc;
        integer cap, err, lim;
        lim = integral_limit_i;
        ev[0] = input_mode_i == 0 ? clampi(tv, 0, 4095) : (input_mode_i == 1 ? analog_input_i : pulse_width_i >> 3);
        ev[1] = input_mode_i == 0 ? ev[0] : scl(ev[0], in_offset_i, in_gain_i);
        ev[2] = feedback_mode_i == 0 ? 0 : (feedback_mode_i == 1 ? analog_feedback_i : clampi(2048 + $signed(tach_freq_i), 0, 4095));
        ev[3] = feedback_mode_i == 0 ? 0 : scl(ev[2], fb_offset_i, fb_gain_i);
        err = ev[3] - ev[1];
        if (feedback_mode_i != 0) begin
            if (err >= 2 * lim) ev[4] = lim;
            else if (-err >= 2 * lim) ev[4] = -lim;
            else ib = 1;
        end
        ev[5] = fmode == 1 ? fval : (feedback_mode_i == 0 ? ev[1] - 2048 : 0);
        cap = max_duty_i > 600 ? 600 : max_duty_i;
        ev[6] = error_halt_i ? 0 : (fmode == 2 ? clampi(fval, -600, 600) : clampi(ev[5], -cap, cap));
        ev[7] = current_ma_i >> 8;
        ev[8] = ov;
        ev[9] = ticks;
        skip = {ov ? 2'b11 : 2'b00, 6'h00, ib ? 2'b11 : 2'b00, 8'h00};
    endtask
    task rdchk(input logic [7:0] off, input logic [5:0] cnt);
        integer i;
        status_host_model_inst.read(off, cnt);
        cmp(8'(status_host_model_inst.got.size()), {2'b00, cnt});
        for (i = 0; i < status_host_model_inst.got.size(); i++)
            if (off + i > 17 || !skip[off + i]) cmp(status_host_model_inst.got[i], eb(off + i));
        cmp({6'h00, force_mode_o}, fmode[7:0]);
    endtask
    initial begin
        ev[4] = 0;
        repeat (20) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        for (k = 0; k < 10; k++) begin
            @(posedge clock_i);
            #1;
            w = {r(), r(), r(), r()};
            x = {r(), r(), r(), r()};
            input_mode_i = k < 6 ? 2'(k % 3) : 2'h0;
            feedback_mode_i = (k < 3 || k > 5) ? 2'h0 : 2'(1 + (k & 1));
            {analog_input_i, analog_feedback_i, pulse_width_i} = w[39:0];
            current_ma_i = w[55:40];
            integral_limit_i = {12'h000, w[58:56]} + 15'h0003;
            {max_duty_i, fb_gain_i, in_gain_i, tach_freq_i} = x[46:0];
            in_offset_i = {4'h0, x[54:47]};
            fb_offset_i = {4'h0, x[62:55]};
            tv = k == 0 ? 65535 : (k > 5 ? 3000 : x[11:0]);
            if (k < 8) cmd(0, tv);
            fmode = (k == 6 || k == 7) ? k - 5 : 0;
            fval = {21'h0, w[10:0]} - 1000;
            if (k == 6 || k == 7) cmd(fmode, fval);
            if (k == 8) cmd(3, 0);
            error_halt_i = k == 8;
            if (k == 9) pid_period_ms_i = 16'h0001;
            ov = k == 9;
            periods(3);
            repeat (4) @(posedge clock_i);
            calc;
            rdchk(k == 9 ? 8'h0E : 8'h00, k == 9 ? 6'd6 : 6'd18);
        end
        test_done;
    end
endmodule
`default_nettype wire
